// ---- dhbp_pkg.sv ----
// Shared constants and types for the dual channel host bus port.
package dhbp_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int CHAN_N = 2;
    localparam int CHAN_A = 0;
    localparam int CHAN_B = 1;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
    localparam logic STROBE_IDLE = 1'b1;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_WRITE = 2'h2
    } dhbp_state_t;
endpackage

// ---- dhbp_edge.sv ----
// Edge finder for one active-low host strobe.
`timescale 1ns/100ps
`default_nettype none
module dhbp_edge
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strobe_n,
    output logic fall,
    output logic rise
);
    import dhbp_pkg::*;

    logic prev_ff;
    logic nxt_prev;

    always_comb
    begin
        nxt_prev = strobe_n;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prev_ff <= STROBE_IDLE;
        else
            prev_ff <= nxt_prev;
    end

    assign fall = prev_ff & ~strobe_n;
    assign rise = ~prev_ff & strobe_n;
endmodule
`default_nettype wire

// ---- dhbp_chan_stat.sv ----
// Registered interrupt and transmitter-ready outputs of one channel.
`timescale 1ns/100ps
`default_nettype none
module dhbp_chan_stat
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic svc_req,
    input wire logic tx_ready,
    output logic irq_ff,
    output logic tx_space_n_ff
);
    import dhbp_pkg::*;

    logic nxt_irq;
    logic nxt_tx_space_n;

    always_comb
    begin
        nxt_irq = svc_req;
        nxt_tx_space_n = ~tx_ready;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_ff <= 1'b0;
            tx_space_n_ff <= 1'b1;
        end
        else
        begin
            irq_ff <= nxt_irq;
            tx_space_n_ff <= nxt_tx_space_n;
        end
    end
endmodule
`default_nettype wire

// ---- dhbp_top.sv ----
// Host bus port of a two-channel serial transceiver.
//
// What this block does
// - Read strobe falling edge starts an internal read at register_select.
// - Device drives the selected byte; host captures it on read strobe rise.
// - Write strobe falling edge starts an internal write cycle.
// - Write strobe rising edge stores the data bus byte into the register.
// - Accesses start only while chip select is low; channel_pick picks channel.
// - channel_pick low selects channel B, high selects channel A.
// - Broadcast bit makes one write update both channels' register.
// - irq_channel_a follows channel A's service request, registered one clock later.
// - irq_channel_b follows channel B's service request, registered one clock later.
// - Each channel has an active-low transmitter-ready output from its transmit status.
// - Three address lines pick one of eight registers over an eight-bit bus.
`timescale 1ns/100ps
`default_nettype none
module dhbp_top
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic channel_pick,
    input wire logic [dhbp_pkg::ADDR_W-1:0] register_select,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [dhbp_pkg::DATA_W-1:0] host_data_bus_in,
    output logic [dhbp_pkg::DATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    input wire logic write_both_en,
    input wire logic [dhbp_pkg::DATA_W-1:0] rd_data_a,
    input wire logic [dhbp_pkg::DATA_W-1:0] rd_data_b,
    output logic reg_rd_a,
    output logic reg_rd_b,
    output logic reg_wr_a,
    output logic reg_wr_b,
    output logic [dhbp_pkg::ADDR_W-1:0] reg_addr,
    output logic [dhbp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic svc_req_a,
    input wire logic svc_req_b,
    input wire logic tx_ready_a,
    input wire logic tx_ready_b,
    output logic irq_channel_a,
    output logic irq_channel_b,
    output logic tx_space_a_n,
    output logic tx_space_b_n
);
    import dhbp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe edges.

    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;

    dhbp_edge u_rd_edge
    (
        .clk(clk),
        .rst_n(rst_n),
        .strobe_n(read_strobe_n),
        .fall(rd_fall),
        .rise(rd_rise)
    );

    dhbp_edge u_wr_edge
    (
        .clk(clk),
        .rst_n(rst_n),
        .strobe_n(write_strobe_n),
        .fall(wr_fall),
        .rise(wr_rise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Access sequencer.

    dhbp_state_t st_ff;
    dhbp_state_t nxt_st;
    logic tgt_a_ff;
    logic tgt_b_ff;
    logic nxt_tgt_a;
    logic nxt_tgt_b;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic rd_a_ff;
    logic rd_b_ff;
    logic nxt_rd_a;
    logic nxt_rd_b;
    logic wr_a_ff;
    logic wr_b_ff;
    logic nxt_wr_a;
    logic nxt_wr_b;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] nxt_wdata;
    logic [DATA_W-1:0] dout_ff;
    logic [DATA_W-1:0] nxt_dout;
    logic oe_n_ff;
    logic nxt_oe_n;
    logic [DATA_W-1:0] rd_mux;

    // A read returns the channel that was picked when the strobe fell.
    assign rd_mux = tgt_a_ff ? rd_data_a : rd_data_b;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_tgt_a = tgt_a_ff;
        nxt_tgt_b = tgt_b_ff;
        nxt_addr = addr_ff;
        nxt_rd_a = 1'b0;
        nxt_rd_b = 1'b0;
        nxt_wr_a = 1'b0;
        nxt_wr_b = 1'b0;
        nxt_wdata = wdata_ff;
        nxt_dout = DATA_RST;
        nxt_oe_n = ~(~cs_n & ~read_strobe_n);
        unique case (st_ff)
            ST_IDLE:
            begin
                if (!cs_n && rd_fall && write_strobe_n)
                begin
                    nxt_st = ST_READ;
                    nxt_addr = register_select;
                    nxt_tgt_a = channel_pick;
                    nxt_tgt_b = ~channel_pick;
                    nxt_rd_a = channel_pick;
                    nxt_rd_b = ~channel_pick;
                end
                else if (!cs_n && wr_fall && read_strobe_n)
                begin
                    nxt_st = ST_WRITE;
                    nxt_addr = register_select;
                    nxt_tgt_a = channel_pick | write_both_en;
                    nxt_tgt_b = ~channel_pick | write_both_en;
                end
            end
            ST_READ:
            begin
                nxt_dout = rd_mux;
                if (rd_rise)
                    nxt_st = ST_IDLE;
            end
            ST_WRITE:
            begin
                if (wr_rise)
                begin
                    nxt_st = ST_IDLE;
                    nxt_wr_a = tgt_a_ff;
                    nxt_wr_b = tgt_b_ff;
                    nxt_wdata = host_data_bus_in;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_ff <= ST_IDLE;
            tgt_a_ff <= 1'b0;
            tgt_b_ff <= 1'b0;
            addr_ff <= ADDR_RST;
            rd_a_ff <= 1'b0;
            rd_b_ff <= 1'b0;
            wr_a_ff <= 1'b0;
            wr_b_ff <= 1'b0;
            wdata_ff <= DATA_RST;
            dout_ff <= DATA_RST;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
            tgt_a_ff <= nxt_tgt_a;
            tgt_b_ff <= nxt_tgt_b;
            addr_ff <= nxt_addr;
            rd_a_ff <= nxt_rd_a;
            rd_b_ff <= nxt_rd_b;
            wr_a_ff <= nxt_wr_a;
            wr_b_ff <= nxt_wr_b;
            wdata_ff <= nxt_wdata;
            dout_ff <= nxt_dout;
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign reg_rd_a = rd_a_ff;
    assign reg_rd_b = rd_b_ff;
    assign reg_wr_a = wr_a_ff;
    assign reg_wr_b = wr_b_ff;
    assign reg_addr = addr_ff;
    assign reg_wdata = wdata_ff;
    assign host_data_bus_out = dout_ff;
    assign host_data_bus_oe_n = oe_n_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel status outputs.

    logic [CHAN_N-1:0] svc_v;
    logic [CHAN_N-1:0] txr_v;
    logic [CHAN_N-1:0] irq_v;
    logic [CHAN_N-1:0] txs_n_v;

    assign svc_v = {svc_req_b, svc_req_a};
    assign txr_v = {tx_ready_b, tx_ready_a};

    for (genvar ch = 0; ch < CHAN_N; ch++)
    begin : g_chan
        dhbp_chan_stat u_stat
        (
            .clk(clk),
            .rst_n(rst_n),
            .svc_req(svc_v[ch]),
            .tx_ready(txr_v[ch]),
            .irq_ff(irq_v[ch]),
            .tx_space_n_ff(txs_n_v[ch])
        );
    end

    assign irq_channel_a = irq_v[CHAN_A];
    assign irq_channel_b = irq_v[CHAN_B];
    assign tx_space_a_n = txs_n_v[CHAN_A];
    assign tx_space_b_n = txs_n_v[CHAN_B];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_rd_start: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_ff == ST_IDLE && !cs_n && $fell(read_strobe_n) && write_strobe_n)
        |=> ((reg_rd_a ^ reg_rd_b) && reg_addr == $past(register_select)
            && st_ff == ST_READ))
        else $error("read strobe fall did not start a read");

    a_rd_data_out: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_ff == ST_READ) |=> (host_data_bus_out == $past(rd_mux)))
        else $error("read byte not presented on the data bus");

    a_wr_start: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_ff == ST_IDLE && !cs_n && $fell(write_strobe_n) && read_strobe_n)
        |=> (st_ff == ST_WRITE && !reg_wr_a && !reg_wr_b))
        else $error("write strobe fall did not start a write");

    a_wr_store: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_ff == ST_WRITE && $rose(write_strobe_n))
        |=> ((reg_wr_a || reg_wr_b) && reg_wdata == $past(host_data_bus_in)
            && st_ff == ST_IDLE))
        else $error("write strobe rise did not store the byte");

    a_cs_gates: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_ff == ST_IDLE && cs_n)
        |=> (st_ff == ST_IDLE && !reg_rd_a && !reg_rd_b) ##1 (!reg_wr_a && !reg_wr_b))
        else $error("access taken without chip select");

    a_pick_chan: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_ff == ST_IDLE && !cs_n && $fell(write_strobe_n) && read_strobe_n
            && !write_both_en)
        |=> (tgt_a_ff == $past(channel_pick) && tgt_b_ff == !$past(channel_pick)))
        else $error("wrong channel chosen");

    a_both_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_ff == ST_IDLE && !cs_n && $fell(write_strobe_n) && read_strobe_n
            && write_both_en)
        |=> (tgt_a_ff && tgt_b_ff))
        else $error("broadcast write did not select both channels");

    a_irq_a_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> (irq_channel_a == $past(svc_req_a)))
        else $error("channel A interrupt does not follow its request");

    a_irq_b_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> (irq_channel_b == $past(svc_req_b)))
        else $error("channel B interrupt does not follow its request");

    a_tx_space_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> (tx_space_a_n != $past(tx_ready_a)
            && tx_space_b_n != $past(tx_ready_b)))
        else $error("transmitter ready outputs wrong");

    a_bus_drive: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> (host_data_bus_oe_n == ($past(cs_n) || $past(read_strobe_n))))
        else $error("data bus driven outside a read");

    c_read_a: cover property (@(posedge clk) disable iff (!rst_n)
        reg_rd_a ##[1:20] (st_ff == ST_IDLE));
    c_write_b: cover property (@(posedge clk) disable iff (!rst_n)
        reg_wr_b && !reg_wr_a);
    c_write_both: cover property (@(posedge clk) disable iff (!rst_n)
        reg_wr_a && reg_wr_b);
endmodule
`default_nettype wire

// ---- dhbp_host.sv ----
// Host processor model that runs byte transfers on the parallel host bus.
`timescale 1ns/100ps
`default_nettype none
module dhbp_host
(
    input wire logic clk,
    input wire logic [7:0] bus,
    output logic cs_n,
    output logic pick,
    output logic [2:0] sel,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] dat
);
    logic drv;
    logic [7:0] wdat;
    logic [7:0] noise;
    initial
    begin
        cs_n = 1'b1;
        pick = 1'b0;
        sel = 3'h0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        drv = 1'b0;
        wdat = 8'h00;
        noise = 8'hA5;
    end
    // A released bus shows a pattern that changes every cycle.
    always @(posedge clk)
    begin
        noise <= ~noise;
    end
    assign dat = drv ? wdat : noise;
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic rd, input logic cs, input logic ch,
                        input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cs_n <= !cs;
        pick <= ch;
        sel <= a;
        wdat <= d;
        drv <= !rd;
        rd_n <= !rd;
        wr_n <= rd;
        repeat (4) @(posedge clk);
        q = bus;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        @(posedge clk);
        cs_n <= 1'b1;
        drv <= 1'b0;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench of the host bus port.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dhbp_pkg::*;
    logic clk = 1'b0;
    logic rst_n, both, sa, sb, ta, tb_r;
    logic cs_n, pick, rd_n, wr_n, oe_n, rra, rrb, rwa, rwb, ia, ib, xa_n, xb_n;
    logic [2:0] sel, raddr;
    logic [7:0] hdat, dout, bus, wd, q, d;
    logic [7:0] mem_a [8];
    logic [7:0] mem_b [8];
    int exp_a [8];
    int exp_b [8];
    int n_mismatch = 0;
    int total_checks = 0;
    int n_rd = 0;
    int rd_seen = 0;
    always #50 clk = ~clk;
    assign bus = !oe_n ? dout : hdat;
    dhbp_host host (.clk(clk), .bus(bus), .cs_n(cs_n), .pick(pick), .sel(sel),
        .rd_n(rd_n), .wr_n(wr_n), .dat(hdat));
    dhbp_top uut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .channel_pick(pick),
        .register_select(sel), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe_n(oe_n),
        .write_both_en(both), .rd_data_a(mem_a[raddr]), .rd_data_b(mem_b[raddr]),
        .reg_rd_a(rra), .reg_rd_b(rrb), .reg_wr_a(rwa), .reg_wr_b(rwb),
        .reg_addr(raddr), .reg_wdata(wd), .svc_req_a(sa), .svc_req_b(sb),
        .tx_ready_a(ta), .tx_ready_b(tb_r), .irq_channel_a(ia), .irq_channel_b(ib),
        .tx_space_a_n(xa_n), .tx_space_b_n(xb_n));
    // Channel register files seen through the port.
    always @(posedge clk)
    begin
        if (rwa) mem_a[raddr] <= wd;
        if (rwb) mem_b[raddr] <= wd;
        if (rra | rrb) rd_seen++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
        total_checks++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(6));
        rst_n = 1'b0;
        both = 1'b0;
        {sa, sb, ta, tb_r} = 4'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(dout, 8'h00);
        chk({7'h0, oe_n}, 8'h01);
        chk({ia, ib, xa_n, xb_n}, 8'h03);
        for (int i = 0; i < 16; i++)
        begin
            d = 8'($urandom);
            host.xfer(1'b0, 1'b1, i[3], i[2:0], d, q);
            if (i[3]) exp_a[i % 8] = d;
            else exp_b[i % 8] = d;
        end
        both <= 1'b1;
        host.xfer(1'b0, 1'b1, 1'b0, 3'h5, 8'h5A, q);
        both <= 1'b0;
        exp_a[5] = 8'h5A;
        exp_b[5] = 8'h5A;
        host.xfer(1'b0, 1'b0, 1'b1, 3'h2, ~8'(exp_a[2]), q);
        for (int i = 0; i < 16; i++)
        begin
            host.xfer(1'b1, 1'b1, i[3], i[2:0], 8'h00, q);
            n_rd++;
            chk(q, 8'(i[3] ? exp_a[i % 8] : exp_b[i % 8]));
            #1;
            chk({7'h0, oe_n}, 8'h01);
        end
        chk(8'(rd_seen), 8'(n_rd));
        repeat (24)
        begin
            @(posedge clk);
            d = 8'($urandom);
            {sa, sb, ta, tb_r} <= d[3:0];
            @(posedge clk);
            #1;
            chk({ia, ib, xa_n, xb_n}, {4'h0, d[3:2], ~d[1:0]});
        end
        close_out();
    end
endmodule
`default_nettype wire
